// >>> core/dpw_defines.svh
`ifndef DPW_DEFINES_SVH
`define DPW_DEFINES_SVH

// register byte offsets on the ahb-lite bus
`define DPW_OFF_DUTY0 12'h000
`define DPW_OFF_DUTY1 12'h004
`define DPW_OFF_CTRL 12'h008
`define DPW_OFF_STATUS 12'h00c

// control register field positions
`define DPW_CTRL_MODE_BIT 7
`define DPW_CTRL_EN1_BIT 6
`define DPW_CTRL_EN0_BIT 5

// reset values
`define DPW_CTRL_RESET 8'h00
`define DPW_DUTY_RESET 8'h00

// cycle geometry
`define DPW_CYCLE_CLKS 256
`define DPW_SUB4_CLKS 64
`define DPW_SUB2_CLKS 128

// ahb encodings
`define DPW_HTRANS_NONSEQ 2'b10
`define DPW_HTRANS_SEQ 2'b11

`endif

// >>> core/dpw_pkg.sv
package dpw_pkg;

  // control register contents; low bits belong to unrelated configuration
  typedef struct packed {
    logic subcycle_select;
    logic channel1_enable;
    logic channel0_enable;
    logic [4:0] buzzer_cfg;
  } dpw_ctrl_t;

  // one channel's split of the duty value
  typedef struct packed {
    logic [6:0] coarse_duty;
    logic [1:0] fine_duty;
  } dpw_split_t;

  // bus slave states
  typedef enum logic [1:0] {
    DPW_IDLE = 2'b01,
    DPW_DATA = 2'b10
  } dpw_bus_state_t;

endpackage

// >>> core/dpw_channel.sv
`include "dpw_defines.svh"

// one pwm channel: compares the sub-cycle position against the high time
module dpw_channel (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // settings
  input wire logic [7:0] pwm_duty_value,
  input wire logic subcycle_select,
  input wire logic channel_enable,
  // shared cycle counter
  input wire logic [7:0] cycle_cnt,
  // output
  output logic pwm_out
);

  dpw_pkg::dpw_split_t split;
  logic [1:0] sub_idx;
  logic [6:0] pos;
  logic [7:0] high_clks;
  logic pwm_nxt;
  logic pwm_r;

  // split duty into coarse and fine parts per mode
  always_comb begin
    if (subcycle_select) begin
      split.coarse_duty = {1'b0, pwm_duty_value[7:2]}; // R10
      split.fine_duty = pwm_duty_value[1:0]; // R10
      sub_idx = cycle_cnt[7:6]; // R9
      pos = {1'b0, cycle_cnt[5:0]};
    end else begin
      split.coarse_duty = pwm_duty_value[7:1]; // R13
      split.fine_duty = {1'b0, pwm_duty_value[0]}; // R13
      sub_idx = {1'b0, cycle_cnt[7]}; // R12
      pos = cycle_cnt[6:0];
    end
    // extra clock only in the first fine_duty sub-cycles
    high_clks = {1'b0, split.coarse_duty} + ((sub_idx < split.fine_duty) ? 8'h01 : 8'h00); // R11 R14
    // high first, then low; disabled channel stays low
    pwm_nxt = channel_enable && ({1'b0, pos} < high_clks); // R16 R7
  end

  // registered output keeps the data output glitch free
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_r <= 1'b0;
    end else begin
      pwm_r <= pwm_nxt;
    end
  end

  assign pwm_out = pwm_r;

endmodule // dpw_channel

// >>> core/dpw_top.sv
// How it works
// (R1) two independent pwm channels, each with its own software 8-bit duty
// (R2) each duty register sets the duty of a whole modulation cycle
// (R3) counters advance on every system clock, no prescaler
// (R4) full cycle is 256 clocks; average duty is value over 256
// (R5) hardware splits cycles into sub-cycles on its own
// (R6) control bit 7 picks mode: 0 two sub-cycles, 1 four; resets zero
// (R7) control bit 5 enables channel 0, bit 6 enables channel 1
// (R8) control bits 4 to 0 are stored but never affect pwm
// (R9) four-sub-cycle mode: sub-cycles 0 to 3, 64 clocks each
// (R10) four-sub-cycle mode: bits 7..2 coarse, bits 1..0 fine
// (R11) four mode: sub-cycle high coarse+1 if index below fine, else coarse
// (R12) two-sub-cycle mode: sub-cycles 0 and 1, 128 clocks each
// (R13) two-sub-cycle mode: bits 7..1 coarse, bit 0 fine
// (R14) two mode: sub-cycle high coarse+1 if index below fine, else coarse
// (R15) pwm outputs stay internal, never driving a device pin
// (R16) each sub-cycle starts high for its count, then low; disabled is low
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`include "dpw_defines.svh"

module dpw_top (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // internal pwm outputs
  output logic [1:0] pwm_out
);

  logic [7:0] duty_r [2];
  logic [7:0] duty_nxt [2];
  dpw_pkg::dpw_ctrl_t ctrl_r;
  dpw_pkg::dpw_ctrl_t ctrl_nxt;
  dpw_pkg::dpw_bus_state_t state_r;
  dpw_pkg::dpw_bus_state_t state_nxt;
  logic [11:0] addr_r;
  logic [11:0] addr_nxt;
  logic wr_r;
  logic wr_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [7:0] cycle_cnt_r;
  logic [7:0] cycle_cnt_nxt;
  logic take;

  // accept a transfer on a valid address phase
  assign take = hsel && hready && (htrans == `DPW_HTRANS_NONSEQ || htrans == `DPW_HTRANS_SEQ);
  // zero-wait slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;

  // bus state: latch address phase, write in data phase, read data ready on data phase
  always_comb begin
    state_nxt = take ? dpw_pkg::DPW_DATA : dpw_pkg::DPW_IDLE;
    addr_nxt = take ? haddr : addr_r;
    wr_nxt = take && hwrite;
    duty_nxt = duty_r;
    ctrl_nxt = ctrl_r;
    rdata_nxt = rdata_r;
    if (state_r == dpw_pkg::DPW_DATA && wr_r) begin
      case (addr_r)
        `DPW_OFF_DUTY0: begin
          duty_nxt[0] = hwdata[7:0]; // R1 R2
        end
        `DPW_OFF_DUTY1: begin
          duty_nxt[1] = hwdata[7:0]; // R1 R2
        end
        `DPW_OFF_CTRL: begin
          ctrl_nxt = dpw_pkg::dpw_ctrl_t'(hwdata[7:0]); // R6 R7 R8
        end
        default: begin
          ctrl_nxt = ctrl_r; // unmapped or read-only: ignored
        end
      endcase
    end
    // read data prepared from the address phase, so it stands in the data phase
    if (take && !hwrite) begin
      case (haddr)
        `DPW_OFF_DUTY0: rdata_nxt = {24'h000000, duty_r[0]};
        `DPW_OFF_DUTY1: rdata_nxt = {24'h000000, duty_r[1]};
        `DPW_OFF_CTRL: rdata_nxt = {24'h000000, ctrl_r};
        `DPW_OFF_STATUS: rdata_nxt = {22'h0, pwm_out, cycle_cnt_r};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // bus registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= dpw_pkg::DPW_IDLE;
      addr_r <= 12'h000;
      wr_r <= 1'b0;
      rdata_r <= 32'h00000000;
      duty_r[0] <= `DPW_DUTY_RESET;
      duty_r[1] <= `DPW_DUTY_RESET;
      ctrl_r <= `DPW_CTRL_RESET; // R6
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      wr_r <= wr_nxt;
      rdata_r <= rdata_nxt;
      duty_r <= duty_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  // free-running 256-clock cycle counter on the system clock; wraps naturally
  always_comb begin
    cycle_cnt_nxt = cycle_cnt_r + 8'h01; // R3 R4 R5
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cycle_cnt_r <= 8'h00;
    end else begin
      cycle_cnt_r <= cycle_cnt_nxt;
    end
  end

  // one channel per generate entry; outputs go to internal logic only
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    dpw_channel u_ch (
      .hclk(hclk),
      .hresetn(hresetn),
      .pwm_duty_value(duty_r[ch]),
      .subcycle_select(ctrl_r.subcycle_select), // R6
      .channel_enable(ch == 0 ? ctrl_r.channel0_enable : ctrl_r.channel1_enable), // R7
      .cycle_cnt(cycle_cnt_r),
      .pwm_out(pwm_out[ch]) // R15
    );
  end

endmodule // dpw_top

// >>> bench/dpw_top_sva.sv
`include "dpw_defines.svh"
module dpw_checker (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // pwm
  input wire logic [1:0] pwm_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // taken transfers; reads and writes of any size are decoded, hsize is not looked at
  wire logic rd = hsel && hready && htrans[1] && !hwrite;
  wire logic wr = hsel && hready && htrans[1] && hwrite;
  wire logic rd_st = rd && haddr == `DPW_OFF_STATUS;
  property ctrl_rb;
    logic [7:0] v;
    wr && haddr == `DPW_OFF_CTRL ##1 (1, v = hwdata[7:0]) ##1 rd && haddr == `DPW_OFF_CTRL |=> hrdata[7:0] == v;
  endproperty
  zero_wait_a: assert property (hreadyout) else $error("wait state");
  okay_resp_a: assert property (!hresp) else $error("error response");
  reset_low_a: assert property ($rose(hresetn) |-> (pwm_out == 2'h0) [*3]) else $error("pwm after reset");
  no_prescale_a: assert property (rd_st ##2 rd_st |=> hrdata[7:0] == $past(hrdata[7:0]) + 8'h02)
    else $error("count step");
  status_pwm_a: assert property (rd_st |=> hrdata[9:8] == $past(pwm_out)) else $error("status pwm");
  upper_zero_a: assert property (rd && haddr != `DPW_OFF_STATUS |=> hrdata[31:8] == 24'h0) else $error("upper bits");
  unmapped_zero_a: assert property (rd && haddr > 12'h00c |=> hrdata == 32'h0) else $error("unmapped read");
  ctrl_back_a: assert property (ctrl_rb) else $error("ctrl readback");
  cover property (rd_st);
  cover property ($rose(pwm_out[0]));
  cover property ($rose(pwm_out[1]));
endmodule // dpw_checker

bind dpw_top dpw_checker u_dpw_checker (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .hreadyout, .hresp, .pwm_out);

// >>> bench/dual_pwm_subcycle_generator_bench.sv
`include "dpw_defines.svh"
module dual_pwm_subcycle_generator_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, hready, hreadyout, hresp;
  logic [11:0] haddr = 12'h0;
  logic [1:0] htrans = 2'h0;
  logic [1:0] pwm_out;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  int num_errors = 0, samples_checked = 0;
  // ctrl, duty0, duty1, then high clocks and rises per 256 for each channel
  int cfg[4][7] = '{'{255, 101, 255, 101, 4, 255, 1}, '{127, 101, 3, 101, 2, 3, 2},
    '{32, 1, 128, 1, 1, 0, 0}, '{192, 64, 2, 0, 0, 2, 2}};
  assign hready = hreadyout;
  dpw_top u_dpw_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .pwm_out);
  initial forever #50 hclk = ~hclk;
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // a wait that never ends counts as a mismatch
  task automatic wait_rdy();
    int n = 0;
    do begin
      @(posedge hclk);
      n++;
      if (n > 50) begin
        num_errors++;
        close_out();
      end
    end while (hready !== 1'h1);
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  // counting over one full cycle does not need to know the phase
  task automatic measure(input int ch, input logic [31:0] hi, input logic [31:0] rises);
    logic [31:0] h = 0, r = 0;
    logic p;
    @(posedge hclk);
    p = pwm_out[ch];
    repeat (256) begin
      @(posedge hclk);
      h += pwm_out[ch];
      r += pwm_out[ch] & !p;
      p = pwm_out[ch];
    end
    check("high clocks", hi, h);
    check("rises", rises, r);
  endtask
  task automatic t_reset();
    bus(1'h0, `DPW_OFF_CTRL, 32'h0);
    check("ctrl reset", 32'h0, rd);
    bus(1'h0, `DPW_OFF_DUTY1, 32'h0);
    check("duty1 reset", 32'h0, rd);
    bus(1'h0, 12'h010, 32'h0);
    check("unmapped", 32'h0, rd);
    $display("test reset done");
  endtask
  task automatic t_cfg(input int k);
    bus(1'h1, `DPW_OFF_DUTY0, cfg[k][1]);
    bus(1'h1, `DPW_OFF_DUTY1, cfg[k][2]);
    bus(1'h1, `DPW_OFF_CTRL, cfg[k][0]);
    bus(1'h0, `DPW_OFF_CTRL, 32'h0);
    check("ctrl", cfg[k][0], rd);
    bus(1'h0, `DPW_OFF_STATUS, 32'h0);
    bus(1'h0, `DPW_OFF_STATUS, 32'h0);
    measure(0, cfg[k][3], cfg[k][4]);
    measure(1, cfg[k][5], cfg[k][6]);
    $display("test config %0d done", k);
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    t_reset();
    foreach (cfg[k]) t_cfg(k);
    close_out();
  end
endmodule // dual_pwm_subcycle_generator_bench
